// File: rtl/csr_pkg.sv
// Package for the SYSREF, range and power register slice
package csr_pkg;
  // ==========================================================
  // Byte offsets and reset values
  localparam logic [7:0] CSR_OFS_SREF_POS = 8'h2c;
  localparam logic [7:0] CSR_OFS_FULLSCALE_ADJUST = 8'h30;
  localparam logic [7:0] CSR_OFS_PWR_A = 8'h37;
  localparam logic [7:0] CSR_OFS_TS_CTRL = 8'h3b;
  localparam logic [7:0] CSR_OFS_REFO_CTRL = 8'h3c;
  localparam logic [7:0] CSR_OFS_INTERLOCK = 8'h40;
  localparam logic [15:0] CSR_RST_FULLSCALE_ADJUST = 16'ha000;
  localparam logic [7:0] CSR_RST_PWR_A = 8'h4b;
  localparam logic [7:0] CSR_RST_TS_CTRL = 8'h00;
  localparam logic [7:0] CSR_RST_REFO_CTRL = 8'h01;
  localparam logic [7:0] CSR_PWR_HIGH_PERF = 8'h4b;
  localparam logic [7:0] CSR_PWR_LOW_POWER = 8'h46;
  localparam int CSR_TS_RECV_BIT = 0;
  localparam int CSR_TS_PECL_BIT = 1;
  localparam int CSR_REFO_EN_BIT = 0;
  localparam int CSR_ILK_CAL_BIT = 0;
  localparam int CSR_ILK_LINK_BIT = 1;
  localparam int CSR_ILK_BLOCK_BIT = 2;

  // ==========================================================
  // Pin-facing control bundle
  typedef struct packed {
    logic ts_receiver_enable;
    logic ts_pecl_input_mode;
    logic refclk_output_on;
    logic low_power_mode;
  } csr_ctrl_t;
endpackage : csr_pkg

// File: rtl/csr_regs.sv
// Byte-wide register slice: SYSREF position, full-scale, power, timestamp
`timescale 1ns/10ps
//
// Contract
// - Read-only 24-bit SYSREF edge position at byte 0x2C upward.
// - Full-scale range, 16 bits at 0x30, reset 0xA000, all channels.
// - Power byte 0x37 reset 0x4B; 0x4B high perf, 0x46 low power.
// - Timestamp control 0x3B, bit 0 enables timestamp receiver.
// - Timestamp control bit 1 selects PECL mode, no self-bias.
// - Reference output control at 0x3C resets to 0x01.
// - Bit 0 enables reference output whenever the PLL runs.
module csr_regs import csr_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave, byte data
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Device state in
  input wire logic [23:0] sysref_edge_position,
  input wire logic pll_enable,
  input wire logic cal_enable,
  input wire logic serial_link_enable,
  // Controls out
  output logic [15:0] fullscale_adjust,
  output logic [7:0] power_mode_code_a,
  output csr_ctrl_t ctrl
);
  // ==========================================================
  // Input synchronisers
  logic [23:0] pos_s1_r, pos_s2_r;
  logic [2:0] lvl_s1_r, lvl_s2_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_s1_r <= '0;
      pos_s2_r <= '0;
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
    end else begin
      pos_s1_r <= sysref_edge_position;
      pos_s2_r <= pos_s1_r;
      lvl_s1_r <= {serial_link_enable, cal_enable, pll_enable};
      lvl_s2_r <= lvl_s1_r;
    end
  end
  logic pll_on, cal_on, link_on;
  assign pll_on = lvl_s2_r[0];
  assign cal_on = lvl_s2_r[1];
  assign link_on = lvl_s2_r[2];

  // ==========================================================
  // Register state
  logic [15:0] fs_r, fs_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic [7:0] ts_r, ts_nxt;
  logic [7:0] refo_r, refo_nxt;
  logic blocked_r, blocked_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [1:0] resp_r, resp_nxt;
  logic ack_r, ack_nxt;
  csr_ctrl_t ctrl_r, ctrl_nxt;
  logic req;
  logic [7:0] rd_mux;
  logic hit;

  // One wait cycle, then acknowledge
  assign req = (avs_read | avs_write) & ~ack_r;

  always_comb begin
    fs_nxt = fs_r;
    pwr_nxt = pwr_r;
    ts_nxt = ts_r;
    refo_nxt = refo_r;
    blocked_nxt = blocked_r;
    rd_mux = 8'h00;
    hit = 1'b1;
    // Byte lanes, low byte at the base offset
    if (avs_address == CSR_OFS_SREF_POS) begin
      rd_mux = pos_s2_r[7:0];
    end else if (avs_address == CSR_OFS_SREF_POS + 8'h01) begin
      rd_mux = pos_s2_r[15:8];
    end else if (avs_address == CSR_OFS_SREF_POS + 8'h02) begin
      rd_mux = pos_s2_r[23:16];
    end else if (avs_address == CSR_OFS_FULLSCALE_ADJUST) begin
      rd_mux = fs_r[7:0];
    end else if (avs_address == CSR_OFS_FULLSCALE_ADJUST + 8'h01) begin
      rd_mux = fs_r[15:8];
    end else if (avs_address == CSR_OFS_PWR_A) begin
      rd_mux = pwr_r;
    end else if (avs_address == CSR_OFS_TS_CTRL) begin
      rd_mux = ts_r;
    end else if (avs_address == CSR_OFS_REFO_CTRL) begin
      rd_mux = refo_r;
    end else if (avs_address == CSR_OFS_INTERLOCK) begin
      rd_mux = {5'h00, blocked_r, link_on, cal_on};
    end else begin
      hit = 1'b0;
    end
    if (req && avs_write) begin
      // Position status has no write path
      if (avs_address == CSR_OFS_FULLSCALE_ADJUST) begin
        fs_nxt[7:0] = avs_writedata;
      end else if (avs_address == CSR_OFS_FULLSCALE_ADJUST + 8'h01) begin
        fs_nxt[15:8] = avs_writedata;
      end else if (avs_address == CSR_OFS_PWR_A) begin
        // Change under a running cal or link is dropped and sets the block flag
        if (cal_on || link_on) begin
          blocked_nxt = 1'b1;
        end else begin
          pwr_nxt = avs_writedata;
        end
      end else if (avs_address == CSR_OFS_TS_CTRL) begin
        ts_nxt = avs_writedata;
      end else if (avs_address == CSR_OFS_REFO_CTRL) begin
        refo_nxt = avs_writedata;
      end else if (avs_address == CSR_OFS_INTERLOCK) begin
        blocked_nxt = blocked_r & ~avs_writedata[CSR_ILK_BLOCK_BIT];
      end
    end
  end

  always_comb begin
    ack_nxt = req;
    rdata_nxt = rdata_r;
    resp_nxt = resp_r;
    if (req) begin
      rdata_nxt = avs_read ? rd_mux : 8'h00;
      resp_nxt = hit ? 2'b00 : 2'b11;
    end
    ctrl_nxt.ts_receiver_enable = ts_r[CSR_TS_RECV_BIT];
    ctrl_nxt.ts_pecl_input_mode = ts_r[CSR_TS_PECL_BIT];
    ctrl_nxt.refclk_output_on = refo_r[CSR_REFO_EN_BIT] & pll_on;
    // Reserved codes fall back to high performance
    ctrl_nxt.low_power_mode = (pwr_r == CSR_PWR_LOW_POWER);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fs_r <= CSR_RST_FULLSCALE_ADJUST;
      pwr_r <= CSR_RST_PWR_A;
      ts_r <= CSR_RST_TS_CTRL;
      refo_r <= CSR_RST_REFO_CTRL;
      blocked_r <= 1'b0;
      rdata_r <= 8'h00;
      resp_r <= 2'b00;
      ack_r <= 1'b0;
      ctrl_r <= '0;
    end else begin
      fs_r <= fs_nxt;
      pwr_r <= pwr_nxt;
      ts_r <= ts_nxt;
      refo_r <= refo_nxt;
      blocked_r <= blocked_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
      ack_r <= ack_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_response = resp_r;
  assign avs_waitrequest = ~ack_r;
  assign fullscale_adjust = fs_r;
  assign power_mode_code_a = pwr_r;
  assign ctrl = ctrl_r;

  // ==========================================================
  // Checks
  sequence s_pwr_write;
    avs_write && !avs_waitrequest && avs_address == CSR_OFS_PWR_A;
  endsequence

  a_reset_values: assert property (@(posedge clk)
    $past(rst) |-> fs_r == 16'ha000 && pwr_r == 8'h4b
      && ts_r == 8'h00 && refo_r == 8'h01)
    else $error("reset values wrong");

  a_fs_low_write: assert property (@(posedge clk) disable iff (rst)
    avs_write && !avs_waitrequest && avs_address == 8'h30
      |=> fs_r[7:0] == $past(avs_writedata))
    else $error("full-scale low byte not stored");

  a_fs_high_write: assert property (@(posedge clk) disable iff (rst)
    avs_write && !avs_waitrequest && avs_address == 8'h31
      |=> fs_r[15:8] == $past(avs_writedata))
    else $error("full-scale high byte not stored");

  a_pwr_free_write: assert property (@(posedge clk) disable iff (rst)
    s_pwr_write ##0 (!cal_on && !link_on)
      |=> pwr_r == $past(avs_writedata))
    else $error("power byte not stored");

  a_pwr_interlock: assert property (@(posedge clk) disable iff (rst)
    s_pwr_write ##0 (cal_on || link_on)
      |=> $stable(pwr_r) && blocked_r)
    else $error("power byte changed under interlock");

  a_pos_read: assert property (@(posedge clk) disable iff (rst)
    avs_read && avs_waitrequest && avs_address == 8'h2e
      |=> !avs_waitrequest && avs_readdata == $past(pos_s2_r[23:16]))
    else $error("position top byte wrong");

  a_ts_outputs: assert property (@(posedge clk) disable iff (rst)
    ##1 ctrl.ts_receiver_enable == $past(ts_r[0])
      && ctrl.ts_pecl_input_mode == $past(ts_r[1]))
    else $error("timestamp controls wrong");

  a_refo_follow: assert property (@(posedge clk) disable iff (rst)
    refo_r[0] && pll_on ##1 refo_r[0] |-> ctrl.refclk_output_on)
    else $error("reference output not enabled");

  a_lp_decode: assert property (@(posedge clk) disable iff (rst)
    pwr_r == 8'h4b |=> !ctrl.low_power_mode || pwr_r != 8'h4b)
    else $error("high performance code decoded wrong");

  a_pos_no_write: assert property (@(posedge clk) disable iff (rst)
    avs_write && !avs_waitrequest && avs_address == 8'h2c
      |-> avs_response == 2'b00)
    else $error("position write not answered");

  // ==========================================================
  // Handshake and readback checks
  // Request seen in its taken cycle, before the ack goes out
  sequence s_req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_wr_taken;
    s_req_taken ##0 avs_write;
  endsequence

  a_wait_answer: assert property (@(posedge clk) disable iff (rst)
    s_req_taken |=> !avs_waitrequest)
    else $error("request not answered in one cycle");

  a_wait_single: assert property (@(posedge clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge held too long");

  a_pos_low_read: assert property (@(posedge clk) disable iff (rst)
    s_req_taken ##0 (avs_read && avs_address == 8'h2c)
      |=> avs_readdata == $past(pos_s2_r[7:0]))
    else $error("position low byte wrong");

  a_pos_mid_read: assert property (@(posedge clk) disable iff (rst)
    s_req_taken ##0 (avs_read && avs_address == 8'h2d)
      |=> avs_readdata == $past(pos_s2_r[15:8]))
    else $error("position middle byte wrong");

  a_fs_low_read: assert property (@(posedge clk) disable iff (rst)
    s_req_taken ##0 (avs_read && avs_address == 8'h30)
      |=> avs_readdata == $past(fs_r[7:0]))
    else $error("full-scale low byte read wrong");

  a_fs_high_read: assert property (@(posedge clk) disable iff (rst)
    s_req_taken ##0 (avs_read && avs_address == 8'h31)
      |=> avs_readdata == $past(fs_r[15:8]))
    else $error("full-scale high byte read wrong");

  a_pos_no_store: assert property (@(posedge clk) disable iff (rst)
    s_wr_taken ##0 (avs_address >= 8'h2c && avs_address <= 8'h2e)
      |=> $stable(fs_r) && $stable(pwr_r) && $stable(ts_r) && $stable(refo_r))
    else $error("position write disturbed a register");

  a_ts_store: assert property (@(posedge clk) disable iff (rst)
    s_wr_taken ##0 avs_address == 8'h3b
      |=> ts_r == $past(avs_writedata))
    else $error("timestamp control not stored");

  a_refo_store: assert property (@(posedge clk) disable iff (rst)
    s_wr_taken ##0 avs_address == 8'h3c
      |=> refo_r == $past(avs_writedata))
    else $error("reference output control not stored");

  a_lp_code: assert property (@(posedge clk) disable iff (rst)
    pwr_r == 8'h46 |=> ctrl.low_power_mode)
    else $error("low power code not decoded");

  a_reserved_pwr: assert property (@(posedge clk) disable iff (rst)
    pwr_r != 8'h46 |=> !ctrl.low_power_mode)
    else $error("other code decoded as low power");

  a_refo_off: assert property (@(posedge clk) disable iff (rst)
    !refo_r[0] |=> !ctrl.refclk_output_on)
    else $error("reference output on while disabled");

  // Synced pll level gates the output, so a pin pulse caught by a clock
  // edge still reaches the reference output two clocks later
  a_refo_gate: assert property (@(posedge clk) disable iff (rst)
    !pll_on |=> !ctrl.refclk_output_on)
    else $error("reference output on without pll");
endmodule : csr_regs

// File: dv/test_csr_regs.sv
// Self-checking bench for the SYSREF, range and power register slice
`timescale 1ns/10ps
module test_csr_regs import csr_pkg::*; ;
  // ==========================================================
  // Clock, reset and design signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [23:0] sysref_edge_position = 24'h000000;
  logic pll_enable = 1'b0;
  logic cal_enable = 1'b0;
  logic serial_link_enable = 1'b0;
  logic [15:0] fullscale_adjust;
  logic [7:0] power_mode_code_a;
  csr_ctrl_t ctrl;
  int err_count = 0;
  int check_count = 0;
  logic [7:0] q;
  logic [1:0] r;
  always #4 clk = ~clk;
  csr_regs i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .sysref_edge_position(sysref_edge_position), .pll_enable(pll_enable),
    .cal_enable(cal_enable), .serial_link_enable(serial_link_enable),
    .fullscale_adjust(fullscale_adjust),
    .power_mode_code_a(power_mode_code_a), .ctrl(ctrl));
  // ==========================================================
  // Shared tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      err_count++;
    end
  endtask : chk
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Look between edges, then take the answer at the next rising edge
    do begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        $display("[ERR] %0t bus timeout", $time);
        err_count++;
        end_sim();
      end
    end while (avs_waitrequest !== 1'b0);
    @(posedge clk);
    q = avs_readdata;
    r = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk({16'h0, q}, {16'h0, exp}, "read data");
    chk({22'h0, r}, 24'h0, "read response");
  endtask : rd
  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    rd(8'h30, 8'h00);
    rd(8'h31, 8'ha0);
    rd(8'h37, 8'h4b);
    rd(8'h3b, 8'h00);
    rd(8'h3c, 8'h01);
    chk({8'h0, fullscale_adjust}, 24'h00a000, "range out");
    chk({16'h0, power_mode_code_a}, 24'h4b, "power out");
    $display("reset values done");
  endtask : t_reset_values
  task automatic t_edge_status;
    sysref_edge_position <= 24'ha5c31e;
    repeat (4) @(posedge clk);
    rd(8'h2c, 8'h1e);
    rd(8'h2e, 8'ha5);
    bus(1'b1, 8'h2d, 8'h00);
    rd(8'h2d, 8'hc3);
    $display("edge status done");
  endtask : t_edge_status
  task automatic t_range;
    bus(1'b1, 8'h30, 8'h00);
    bus(1'b1, 8'h31, 8'h20);
    chk({8'h0, fullscale_adjust}, 24'h002000, "range min");
    bus(1'b1, 8'h30, 8'hff);
    bus(1'b1, 8'h31, 8'hff);
    rd(8'h30, 8'hff);
    chk({8'h0, fullscale_adjust}, 24'h00ffff, "range max");
    $display("range done");
  endtask : t_range
  task automatic t_power;
    // Blocked while calibration or link is on, so the code must not move
    cal_enable <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, 8'h37, 8'h46);
    rd(8'h37, 8'h4b);
    cal_enable <= 1'b0;
    serial_link_enable <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, 8'h37, 8'h46);
    chk({16'h0, power_mode_code_a}, 24'h4b, "link block");
    rd(8'h40, 8'h06);
    serial_link_enable <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, 8'h40, 8'h04);
    rd(8'h40, 8'h00);
    // Only the first power register lives here; the rest go with it
    bus(1'b1, 8'h37, 8'h46);
    chk({23'h0, ctrl.low_power_mode}, 24'h1, "low power");
    cal_enable <= 1'b1;
    repeat (4) @(posedge clk);
    cal_enable <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, 8'h37, 8'h4b);
    chk({23'h0, ctrl.low_power_mode}, 24'h0, "high perf");
    $display("power done");
  endtask : t_power
  task automatic t_ts_refo;
    bus(1'b1, 8'h3b, 8'h01);
    chk({22'h0, ctrl.ts_receiver_enable, ctrl.ts_pecl_input_mode},
        24'h2, "receiver");
    bus(1'b1, 8'h3b, 8'h02);
    chk({22'h0, ctrl.ts_receiver_enable, ctrl.ts_pecl_input_mode},
        24'h1, "pecl");
    pll_enable <= 1'b1;
    repeat (5) @(posedge clk);
    chk({23'h0, ctrl.refclk_output_on}, 24'h1, "refclk on");
    bus(1'b1, 8'h3c, 8'h00);
    repeat (2) @(posedge clk);
    chk({23'h0, ctrl.refclk_output_on}, 24'h0, "refclk off");
    bus(1'b0, 8'h50, 8'h00);
    chk({22'h0, r}, 24'h3, "unmapped");
    $display("timestamp and refclk done");
  endtask : t_ts_refo
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_edge_status();
    t_range();
    t_power();
    t_ts_refo();
    end_sim();
  end
endmodule : test_csr_regs
